// >>> core/tpg_defs.vh
/*
  tpg_defs.vh: register indices, field positions, reset values, mode codes and
  pattern constants for the converter test pattern generator.
  Assumes it is included by bare name from the design files under core/.
*/
`ifndef TPG_DEFS_VH
`define TPG_DEFS_VH

// register indices; byte address is four times the index
`define IDX_DDC0_CTRL   11'h327
`define IDX_DDC1_CTRL   11'h347
`define IDX_TEST_A      11'h550
`define IDX_USER_FIRST  11'h551
`define IDX_USER_LAST   11'h558
`define IDX_TEST_B      11'h560
`define IDX_APP_MODE    11'h561
`define IDX_STATUS      11'h562

// test register fields
`define TM_SEL_MSB      3
`define TM_SEL_LSB      0
`define TM_PN_RST_LO    4
`define TM_PN_RST_HI    5
`define TM_USER_SINGLE  7

// converter path control and mode fields
`define DDC_TEST_I      0
`define DDC_TEST_Q      2
`define APP_DDC         0

// reset values
`define CTRL_RST        8'h00
`define USER_RST        8'h00

// select codes
`define SEL_MID         4'h1
`define SEL_POS         4'h2
`define SEL_NEG         4'h3
`define SEL_CHK         4'h4
`define SEL_PN_LONG     4'h5
`define SEL_PN_SHORT    4'h6
`define SEL_TOG         4'h7
`define SEL_USER        4'h8
`define SEL_RAMP        4'hf

// fixed pattern words
`define PAT_MID         14'h0000
`define PAT_POS         14'h1fff
`define PAT_NEG         14'h2000
`define PAT_CHK0        14'h1555
`define PAT_CHK1        14'h2aaa
`define PAT_ZERO        14'h0000
`define PAT_ONES        14'h3fff

// sequence generators: length, feedback tap, seed
`define PN_LONG_LEN     23
`define PN_LONG_TAP     5
`define PN_LONG_SEED    23'h00_3aff
`define PN_SHORT_LEN    9
`define PN_SHORT_TAP    4
`define PN_SHORT_SEED   9'h092

// user pattern walk
`define USER_LAST_WORD  3'h3
`define USER_DONE       3'h4

`endif

// >>> core/pn_gen.v
/*
  pn_gen.v: pseudo-random bit stream generator that emits fourteen stream bits
  per sample, first bit in the sample MSB.
  Assumes one sample per clock; reload has priority over advance.
*/
`include "tpg_defs.vh"

module pn_gen #(
  parameter integer     LEN  = 9,
  parameter integer     TAP  = 4,
  parameter [LEN-1:0]   SEED = 1
) (
  input  wire           i_core_clk,
  input  wire           i_rst,
  input  wire           i_reload,
  input  wire           i_advance,
  output reg  [13:0]    o_sample
);

  reg  [LEN-1:0] state_r;
  reg  [LEN-1:0] state_nxt;
  reg            fb;
  integer        i;

  // bit 0 of the state is the oldest stream bit; new bit = oldest xor tap
  always @* begin
    state_nxt = state_r;
    o_sample  = 14'h0000;
    fb        = 1'b0;
    for (i = 0; i < 14; i = i + 1) begin
      o_sample[13 - i] = state_nxt[0];
      fb               = state_nxt[0] ^ state_nxt[TAP];
      state_nxt        = {fb, state_nxt[LEN-1:1]};
    end
  end

  // held at the seed until selected, so the first sample is always the same
  always @(posedge i_core_clk) begin
    if (i_rst || i_reload) begin
      state_r <= SEED;
    end else if (i_advance) begin
      state_r <= state_nxt;
    end
  end

endmodule

// >>> core/adc_test_pattern_gen.v
/*
  adc_test_pattern_gen.v: test pattern generator between the converter core
  and output formatting, for two channels and two decimating paths, with a
  classic Wishbone register slave.
  Assumes all sample inputs come from logic on i_core_clk, one sample per
  clock, and that formatting downstream takes the registered outputs.
  Limitation: the reseed bits are levels, so a sequence stays frozen at its
  seed word for as long as either bit is left set.
*/
// Chosen here: the Wishbone slave port.
`include "tpg_defs.vh"

module adc_test_pattern_gen (
  input  wire          i_core_clk,
  input  wire          i_rst,
  input  wire          i_wb_cyc,
  input  wire          i_wb_stb,
  input  wire          i_wb_we,
  input  wire [12:0]   i_wb_adr,
  input  wire [3:0]    i_wb_sel,
  input  wire [31:0]   i_wb_dat,
  output wire [31:0]   o_wb_dat,
  output wire          o_wb_ack,
  input  wire [13:0]   i_adc_a,
  input  wire [13:0]   i_adc_b,
  input  wire [13:0]   i_ddc0_i,
  input  wire [13:0]   i_ddc0_q,
  input  wire [13:0]   i_ddc1_i,
  input  wire [13:0]   i_ddc1_q,
  output wire [13:0]   o_out_a,
  output wire [13:0]   o_out_b,
  output wire [13:0]   o_ddc0_i,
  output wire [13:0]   o_ddc0_q,
  output wire [13:0]   o_ddc1_i,
  output wire [13:0]   o_ddc1_q,
  output wire          o_test_active
);

  // register file
  reg  [7:0]   test_a_r;
  reg  [7:0]   test_b_r;
  reg  [7:0]   ddc0_ctrl_r;
  reg  [7:0]   ddc1_ctrl_r;
  reg  [7:0]   app_mode_r;
  reg  [7:0]   user_r [0:7];

  // bus slave state
  reg          ack_r;
  reg  [31:0]  dat_r;
  reg  [7:0]   rd_byte;

  // datapath registers
  reg  [13:0]  ddc0_i_r;
  reg  [13:0]  ddc0_q_r;
  reg  [13:0]  ddc1_i_r;
  reg  [13:0]  ddc1_q_r;
  reg          test_active_r;

  // per-channel results gathered from the generate loop
  wire [27:0]  pat_bus;
  wire [27:0]  out_bus;
  wire [1:0]   act_bus;
  wire [1:0]   done_bus;

  wire [10:0]  idx;
  wire [10:0]  uoff;
  wire         in_user;
  wire         req;
  wire         wr;
  wire         app_ddc;

  // per-path test decisions for the decimating outputs
  wire         tst_ddc0_i;
  wire         tst_ddc0_q;
  wire         tst_ddc1_i;
  wire         tst_ddc1_q;

  integer      k;

  // a request is taken once; ack drops in the cycle after it was given
  // the write waits for ack so it lands on the edge at which the master sees it
  assign idx     = i_wb_adr[12:2];
  assign uoff    = idx - `IDX_USER_FIRST;
  assign in_user = (idx >= `IDX_USER_FIRST) && (idx <= `IDX_USER_LAST);
  assign req     = i_wb_cyc & i_wb_stb & ~ack_r;
  assign wr      = i_wb_cyc & i_wb_stb & i_wb_we & ack_r & i_wb_sel[0];
  assign app_ddc = app_mode_r[`APP_DDC];

  // read mux; unmapped indices read as zero
  always @* begin
    rd_byte = 8'h00;
    if (in_user) begin
      rd_byte = user_r[uoff[2:0]];
    end else begin
      case (idx)
        `IDX_TEST_A:    rd_byte = test_a_r;
        `IDX_TEST_B:    rd_byte = test_b_r;
        `IDX_DDC0_CTRL: rd_byte = ddc0_ctrl_r;
        `IDX_DDC1_CTRL: rd_byte = ddc1_ctrl_r;
        `IDX_APP_MODE:  rd_byte = app_mode_r;
        `IDX_STATUS:    rd_byte = {5'h00, done_bus, test_active_r};
        default:        rd_byte = 8'h00;
      endcase
    end
  end

  // bus handshake: read data is caught when the request is taken
  // capturing early means o_wb_dat is already settled when ack rises
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= req;
      if (req) begin
        dat_r <= {24'h00_0000, rd_byte};
      end
    end
  end

  assign o_wb_ack = ack_r;
  assign o_wb_dat = dat_r;

  // writes land on the edge at which the master sees ack; only lane 0 counts
  // writes to unmapped or read-only indices are acked and dropped
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      test_a_r    <= `CTRL_RST;
      test_b_r    <= `CTRL_RST;
      ddc0_ctrl_r <= `CTRL_RST;
      ddc1_ctrl_r <= `CTRL_RST;
      app_mode_r  <= `CTRL_RST;
      for (k = 0; k < 8; k = k + 1) begin
        user_r[k] <= `USER_RST;
      end
    end else if (wr) begin
      if (in_user) begin
        user_r[uoff[2:0]] <= i_wb_dat[7:0];
      end
      case (idx)
        `IDX_TEST_A:    test_a_r    <= i_wb_dat[7:0];
        `IDX_TEST_B:    test_b_r    <= i_wb_dat[7:0];
        `IDX_DDC0_CTRL: ddc0_ctrl_r <= i_wb_dat[7:0];
        `IDX_DDC1_CTRL: ddc1_ctrl_r <= i_wb_dat[7:0];
        `IDX_APP_MODE:  app_mode_r  <= i_wb_dat[7:0];
        default:        app_mode_r  <= app_mode_r;
      endcase
    end
  end

  // one generator per channel: ch 0 is channel A, ch 1 is channel B
  // the channels share the user words but keep their own counters
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : chan
      wire [7:0]   ctl;
      wire [3:0]   sel_now;
      wire [13:0]  adc_in;
      wire         pn_clr;
      wire         same;
      wire         single;
      wire         ph_e;
      wire [2:0]   ui_e;
      wire [13:0]  rp_e;
      wire [15:0]  up_word;
      wire [13:0]  pn_long;
      wire [13:0]  pn_short;
      reg  [3:0]   sel_r;
      reg          phase_r;
      reg  [2:0]   uidx_r;
      reg  [2:0]   uidx_nxt;
      reg  [13:0]  ramp_r;
      reg  [13:0]  out_r;
      reg  [13:0]  pat_c;
      reg          act_c;

      assign ctl     = (ch == 0) ? test_a_r : test_b_r;
      assign adc_in  = (ch == 0) ? i_adc_a : i_adc_b;
      assign sel_now = ctl[`TM_SEL_MSB:`TM_SEL_LSB];
      assign pn_clr  = ctl[`TM_PN_RST_LO] | ctl[`TM_PN_RST_HI];
      assign single  = ctl[`TM_USER_SINGLE];

      // a new code restarts its counters, so its first sample is the first word
      // without this a mode switch would show one stale count word first
      assign same    = (sel_now == sel_r);
      assign ph_e    = same ? phase_r : 1'b0;
      assign ui_e    = same ? uidx_r : 3'h0;
      assign rp_e    = same ? ramp_r : 14'h0000;
      assign up_word = {user_r[{ui_e[1:0], 1'b1}], user_r[{ui_e[1:0], 1'b0}]};

      // sequences sit at their seed until selected, then step every sample
      // holding the idle generator costs a mux but keeps every start repeatable
      pn_gen #(
        .LEN  (`PN_LONG_LEN),
        .TAP  (`PN_LONG_TAP),
        .SEED (`PN_LONG_SEED)
      ) u_pn_long (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_reload   (pn_clr | (sel_now != `SEL_PN_LONG)),
        .i_advance  (sel_now == `SEL_PN_LONG),
        .o_sample   (pn_long)
      );

      pn_gen #(
        .LEN  (`PN_SHORT_LEN),
        .TAP  (`PN_SHORT_TAP),
        .SEED (`PN_SHORT_SEED)
      ) u_pn_short (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_reload   (pn_clr | (sel_now != `SEL_PN_SHORT)),
        .i_advance  (sel_now == `SEL_PN_SHORT),
        .o_sample   (pn_short)
      );

      // user word walk: repeat wraps after word four, single parks on zeros
      // the index also steps outside user mode; a code change restarts it anyway
      always @* begin
        if (single) begin
          uidx_nxt = (ui_e == `USER_DONE) ? `USER_DONE : ui_e + 3'h1;
        end else begin
          uidx_nxt = (ui_e >= `USER_LAST_WORD) ? 3'h0 : ui_e + 3'h1;
        end
      end

      // pattern select; off and unassigned codes pass converter data
      // codes 1001 to 1110 have no pattern and fall through to the samples
      always @* begin
        pat_c = adc_in;
        act_c = 1'b1;
        case (sel_now)
          `SEL_MID:      pat_c = `PAT_MID;
          `SEL_POS:      pat_c = `PAT_POS;
          `SEL_NEG:      pat_c = `PAT_NEG;
          `SEL_CHK:      pat_c = ph_e ? `PAT_CHK1 : `PAT_CHK0;
          `SEL_PN_LONG:  pat_c = pn_long;
          `SEL_PN_SHORT: pat_c = pn_short;
          `SEL_TOG:      pat_c = ph_e ? `PAT_ONES : `PAT_ZERO;
          `SEL_USER:     pat_c = (ui_e == `USER_DONE) ? `PAT_ZERO : up_word[15:2];
          `SEL_RAMP:     pat_c = rp_e;
          default:       act_c = 1'b0;
        endcase
      end

      // counters run every clock regardless of the analog input
      // they are free running; a select change restarts them through same
      always @(posedge i_core_clk) begin
        if (i_rst) begin
          sel_r   <= 4'h0;
          phase_r <= 1'b0;
          uidx_r  <= 3'h0;
          ramp_r  <= 14'h0000;
          out_r   <= 14'h0000;
        end else begin
          sel_r   <= sel_now;
          phase_r <= ~ph_e;
          uidx_r  <= uidx_nxt;
          ramp_r  <= rp_e + 14'h0001;
          out_r   <= pat_c;
        end
      end

      assign pat_bus[ch*14 +: 14] = pat_c;
      assign out_bus[ch*14 +: 14] = out_r;
      assign act_bus[ch]          = act_c;
      assign done_bus[ch]         = (uidx_r == `USER_DONE);
    end
  endgenerate

  // each path needs decimating mode, its own enable and an active code on its channel;
  // an enable with the channel off passes data, so a stray enable bit is harmless
  assign tst_ddc0_i = app_ddc & ddc0_ctrl_r[`DDC_TEST_I] & act_bus[0];
  assign tst_ddc0_q = app_ddc & ddc0_ctrl_r[`DDC_TEST_Q] & act_bus[1];
  assign tst_ddc1_i = app_ddc & ddc1_ctrl_r[`DDC_TEST_I] & act_bus[0];
  assign tst_ddc1_q = app_ddc & ddc1_ctrl_r[`DDC_TEST_Q] & act_bus[1];

  // decimating paths: I takes channel A pattern, Q takes channel B pattern
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      ddc0_i_r      <= 14'h0000;
      ddc0_q_r      <= 14'h0000;
      ddc1_i_r      <= 14'h0000;
      ddc1_q_r      <= 14'h0000;
      test_active_r <= 1'b0;
    end else begin
      ddc0_i_r <= tst_ddc0_i ? pat_bus[13:0] : i_ddc0_i;
      ddc0_q_r <= tst_ddc0_q ? pat_bus[27:14] : i_ddc0_q;
      ddc1_i_r <= tst_ddc1_i ? pat_bus[13:0] : i_ddc1_i;
      ddc1_q_r <= tst_ddc1_q ? pat_bus[27:14] : i_ddc1_q;
      test_active_r <= |act_bus;
    end
  end

  // every output leaves from a flop so formatting sees clean sample edges
  // the pattern word and its flag come from one edge, so they never disagree
  assign o_out_a       = out_bus[13:0];
  assign o_out_b       = out_bus[27:14];
  assign o_ddc0_i      = ddc0_i_r;
  assign o_ddc0_q      = ddc0_q_r;
  assign o_ddc1_i      = ddc1_i_r;
  assign o_ddc1_q      = ddc1_q_r;
  assign o_test_active = test_active_r;

endmodule

// >>> verif/tpg_monitor.sv
/* tpg_monitor.sv: port-level checker for the test pattern generator.
   Assumes it is bound into adc_test_pattern_gen, one clock, synchronous reset. */
module tpg_monitor (
  input wire        i_core_clk,
  input wire        i_rst,
  input wire        i_wb_cyc,
  input wire        i_wb_stb,
  input wire        i_wb_we,
  input wire [31:0] o_wb_dat,
  input wire        o_wb_ack,
  input wire [13:0] i_adc_a,
  input wire [13:0] i_adc_b,
  input wire [13:0] i_ddc0_i,
  input wire [13:0] o_out_a,
  input wire [13:0] o_out_b,
  input wire [13:0] o_ddc0_i,
  input wire        o_test_active
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // bus answers: one cycle after a taken request, one cycle wide
  a_ack_next: assert property (
    i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack) else $error("ack late");
  a_ack_pulse: assert property (
    o_wb_ack |=> !o_wb_ack) else $error("ack too long");
  a_ack_cause: assert property (
    o_wb_ack |-> $past(i_wb_cyc && i_wb_stb)) else $error("ack without request");
  a_rdata_upper: assert property (
    o_wb_ack |-> o_wb_dat[31:8] == 24'h00_0000) else $error("read data upper bits set");
  a_rdata_hold: assert property (
    $past(!(i_wb_cyc && i_wb_stb)) |-> $stable(o_wb_dat)) else $error("read data moved");
  // with no pattern selected the converter data passes one cycle late
  a_pass_adc: assert property (
    !o_test_active && !$past(i_rst) |-> o_out_a == $past(i_adc_a) && o_out_b == $past(i_adc_b))
    else $error("converter data not passed");
  a_pass_ddc: assert property (
    !o_test_active && !$past(i_rst) |-> o_ddc0_i == $past(i_ddc0_i)) else $error("ddc not passed");
  // the mode only changes two cycles after a write is acknowledged
  a_mode_cause: assert property (
    $changed(o_test_active) |-> $past(o_wb_ack, 2) && $past(i_wb_we, 2))
    else $error("mode changed without write");
endmodule

bind adc_test_pattern_gen tpg_monitor tpg_monitor_inst (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
  .i_wb_we(i_wb_we), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_adc_a(i_adc_a),
  .i_adc_b(i_adc_b), .i_ddc0_i(i_ddc0_i), .o_out_a(o_out_a), .o_out_b(o_out_b),
  .o_ddc0_i(o_ddc0_i), .o_test_active(o_test_active));

// >>> verif/fmt_sink.sv
/* fmt_sink.sv: stand-in for output formatting; takes one sample per clock.
   Assumes the generator's registered outputs on the same clock. */
module fmt_sink (
  input  wire        i_core_clk,
  input  wire        i_rst,
  input  wire [13:0] i_smp_a,
  output reg  [13:0] o_last_a
);
  timeunit 1ns;
  timeprecision 1ns;
  // takes every word, pattern or data alike, so a stall upstream shows here
  always @(posedge i_core_clk) begin
    o_last_a <= i_rst ? 14'h0000 : i_smp_a;
  end
endmodule

// >>> verif/tb.sv
/* tb.sv: self-checking bench for the test pattern generator.
   Assumes the design, checker and sink compile first; core/ on the include path. */
`include "tpg_defs.vh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  reg         i_core_clk = 1'b0;
  reg         i_rst = 1'b1;
  reg         i_wb_cyc = 1'b0, i_wb_stb = 1'b0, i_wb_we = 1'b0;
  reg  [12:0] i_wb_adr = 13'h0000;
  reg  [3:0]  i_wb_sel = 4'h0;
  reg  [31:0] i_wb_dat = 32'h0000_0000;
  reg  [31:0] rd;
  reg  [13:0] smp = 14'h0011;
  wire [31:0] o_wb_dat;
  wire        o_wb_ack, o_test_active;
  wire [13:0] o_out_a, o_out_b, o_ddc0_i, o_ddc0_q, o_ddc1_i, o_ddc1_q, o_last_a;
  wire [13:0] i_adc_a = smp, i_adc_b = ~smp, i_ddc0_i = smp ^ 14'h0155;
  wire [13:0] i_ddc0_q = smp ^ 14'h02aa, i_ddc1_i = smp ^ 14'h0aaa, i_ddc1_q = smp ^ 14'h1111;
  int         n_errors = 0, total_checks = 0, cycles = 0;
  adc_test_pattern_gen adc_test_pattern_gen_inst (.i_core_clk(i_core_clk), .i_rst(i_rst),
    .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
    .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
    .i_adc_a(i_adc_a), .i_adc_b(i_adc_b), .i_ddc0_i(i_ddc0_i), .i_ddc0_q(i_ddc0_q),
    .i_ddc1_i(i_ddc1_i), .i_ddc1_q(i_ddc1_q), .o_out_a(o_out_a), .o_out_b(o_out_b),
    .o_ddc0_i(o_ddc0_i), .o_ddc0_q(o_ddc0_q), .o_ddc1_i(o_ddc1_i), .o_ddc1_q(o_ddc1_q),
    .o_test_active(o_test_active));
  fmt_sink fmt_sink_inst (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_smp_a(o_out_a),
    .o_last_a(o_last_a));
  // clock, moving converter samples so a stuck path shows, and the hang limit
  always #5 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) begin
    smp <= smp + 14'h0007;
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    if (n_errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // one classic cycle; returns at the edge where ack is seen, data taken there
  task automatic wb(input logic w, input [10:0] idx, input [7:0] d, input [3:0] s);
    @(posedge i_core_clk);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= w;
    i_wb_adr <= {idx, 2'b00};
    i_wb_sel <= s;
    i_wb_dat <= {24'h00_0000, d};
    do @(posedge i_core_clk); while (o_wb_ack !== 1'b1);
    rd = o_wb_dat;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    i_wb_we <= 1'b0;
  endtask
  task automatic wr(input [10:0] idx, input [7:0] d);
    wb(1'b1, idx, d, 4'h1);
  endtask
  task automatic step();
    @(posedge i_core_clk);
    #1;
  endtask
  task automatic t_regs();
    wb(1'b0, `IDX_TEST_A, 8'h00, 4'hf);
    `CHK(rd, 32'h0000_0000)
    wr(11'h7ff, 8'h5a);
    wb(1'b0, 11'h7ff, 8'h00, 4'hf);
    `CHK(rd, 32'h0000_0000)
    wb(1'b1, `IDX_TEST_A, 8'h04, 4'he);
    wb(1'b0, `IDX_TEST_A, 8'h00, 4'hf);
    `CHK(rd, 32'h0000_0000)
  endtask
  task automatic t_fixed();
    logic [3:0]  c[3] = '{`SEL_MID, `SEL_POS, `SEL_NEG};
    logic [13:0] e[3] = '{14'h0000, 14'h1fff, 14'h2000};
    for (int k = 0; k < 3; k++) begin
      wr(`IDX_TEST_A, {4'h0, c[k]});
      step();
      `CHK(o_out_a, e[k])
      step();
      `CHK(o_last_a, e[k])
    end
    // an unassigned code acts as off and passes the converter sample
    wr(`IDX_TEST_A, 8'h09);
    step();
    `CHK(o_out_a, smp - 14'h0007)
    `CHK(o_test_active, 1'b0)
  endtask
  task automatic t_seq();
    logic [3:0]  c[4] = '{`SEL_CHK, `SEL_TOG, `SEL_PN_LONG, `SEL_PN_SHORT};
    logic [13:0] e[4][5] = '{'{14'h1555, 14'h2aaa, 14'h1555, 14'h2aaa, 14'h1555},
      '{14'h0000, 14'h3fff, 14'h0000, 14'h3fff, 14'h0000},
      '{14'h3fd7, 14'h0002, 14'h26e0, 14'h0a3d, 14'h1ca6},
      '{14'h125b, 14'h3c9a, 14'h2660, 14'h0c65, 14'h0697}};
    for (int k = 0; k < 4; k++) begin
      wr(`IDX_TEST_A, {4'h0, c[k]});
      for (int j = 0; j < 5; j++) begin
        step();
        `CHK(o_out_a, e[k][j])
      end
    end
    // reseed held by either bit keeps the short sequence at its first word
    wr(`IDX_TEST_A, 8'h16);
    step();
    step();
    `CHK(o_out_a, 14'h125b)
    wr(`IDX_TEST_A, 8'h26);
    step();
    `CHK(o_out_a, 14'h125b)
  endtask
  task automatic t_user();
    logic [15:0] p[4] = '{16'h1234, 16'hfedc, 16'h0a5f, 16'h8003};
    for (int k = 0; k < 4; k++) begin
      wr(11'(`IDX_USER_FIRST + 2 * k), p[k][7:0]);
      wr(11'(`IDX_USER_FIRST + 2 * k + 1), p[k][15:8]);
    end
    wr(`IDX_TEST_A, 8'h08);
    for (int j = 0; j < 6; j++) begin
      step();
      `CHK(o_out_a, p[j % 4][15:2])
    end
    wr(`IDX_TEST_A, 8'h00);
    wr(`IDX_TEST_A, 8'h88);
    for (int j = 0; j < 6; j++) begin
      step();
      `CHK(o_out_a, (j < 4) ? p[j][15:2] : 14'h0000)
    end
    wb(1'b0, `IDX_STATUS, 8'h00, 4'hf);
    `CHK(rd, 32'h0000_0003)
  endtask
  task automatic t_ramp_ddc();
    wr(`IDX_TEST_A, {4'h0, `SEL_RAMP});
    for (int j = 0; j < 4; j++) begin
      step();
      `CHK(o_out_a, j[13:0])
    end
    wr(`IDX_APP_MODE, 8'h01);
    wr(`IDX_DDC0_CTRL, 8'h05);
    wr(`IDX_TEST_B, {4'h0, `SEL_POS});
    wr(`IDX_TEST_A, {4'h0, `SEL_CHK});
    step();
    `CHK(o_ddc0_i, 14'h1555)
    `CHK(o_ddc0_q, 14'h1fff)
    `CHK(o_ddc1_i, (smp - 14'h0007) ^ 14'h0aaa)
    `CHK(o_ddc1_q, (smp - 14'h0007) ^ 14'h1111)
    `CHK(o_out_b, 14'h1fff)
    `CHK(o_test_active, 1'b1)
    step();
    `CHK(o_ddc0_i, 14'h2aaa)
  endtask
  // a reset in mid-pattern returns to plain data
  task automatic t_reset();
    @(posedge i_core_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    i_rst <= 1'b0;
    step();
    `CHK(o_out_a, smp - 14'h0007)
    `CHK(o_test_active, 1'b0)
    wb(1'b0, `IDX_TEST_B, 8'h00, 4'hf);
    `CHK(rd, 32'h0000_0000)
  endtask
  initial begin
    repeat (5) @(posedge i_core_clk);
    i_rst <= 1'b0;
    t_regs();
    t_fixed();
    t_seq();
    t_user();
    t_ramp_ddc();
    t_reset();
    wrap_up();
  end
endmodule
